// *** pkg/ocp_defs.svh ***
`ifndef OCP_DEFS_SVH
`define OCP_DEFS_SVH
// Register offsets
`define OCP_RELOAD_ADDR   8'h97
`define OCP_MODE_ADDR     8'h8F
// Mode register fields
`define OCP_MODE_DBL_BIT  0
`define OCP_MODE_ACT_BIT  1
// Reset value, fastest reload setting and reload span
`define OCP_RELOAD_RST    8'hFF
`define OCP_FASTEST       8'hFF
`define OCP_RELOAD_SPAN   10'h0FF
// Division figures
`define OCP_PER_DBL_FAST  10'h001
`define OCP_PER_STD_FAST  10'h002
`define OCP_PER_SLOW_STD  10'd1020
`define OCP_PER_SLOW_X2   10'd510
`define OCP_OSC_DBL_MC    4'd6
`define OCP_OSC_STD_MC    4'd12
`endif

// *** pkg/ocp_pkg.sv ***
`default_nettype none
package ocp_pkg;
   typedef logic [7:0] ocp_byte_t;
   typedef logic [9:0] ocp_cnt_t;
endpackage
`default_nettype wire

// *** rtl/ocp_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ocp_defs.svh"
module ocp_prescaler (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               hardware_config_byte_dbl_i,
   input  wire ocp_pkg::ocp_byte_t addr_i,
   input  wire ocp_pkg::ocp_byte_t wdata_i,
   input  wire logic               we_i,
   input  wire logic               re_i,
   output ocp_pkg::ocp_byte_t      rdata_o,
   output logic                    cpu_clk_en_o,
   output logic                    periph_clk_en_o,
   output logic                    osc_clk_en_o,
   output logic                    oscillator_source_select_o,
   output logic                    double_speed_o,
   output logic [3:0]              osc_per_machine_cycle_o
);
   import ocp_pkg::*;

   // ****************************************
   // Register decode
   // ****************************************
   ocp_byte_t clock_divider_reload;
   logic      double_speed_select;
   logic      dbl_active;
   logic      cfg_loaded;
   logic      div2;
   ocp_cnt_t  cnt;
   wire       hit_reload = (addr_i == `OCP_RELOAD_ADDR);
   wire       hit_mode   = (addr_i == `OCP_MODE_ADDR);
   wire       wr_reload  = we_i & hit_reload;
   wire       wr_mode    = we_i & hit_mode;
   wire ocp_byte_t mode_rd = {6'h00, dbl_active, double_speed_select};
   wire ocp_byte_t next_rdata = hit_reload ? clock_divider_reload :
                                hit_mode   ? mode_rd : 8'h00;

   // Reload register, software writable across full range
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_divider_reload <= `OCP_RELOAD_RST;
      end else if (wr_reload) begin
         clock_divider_reload <= wdata_i;
      end
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= re_i ? next_rdata : 8'h00;
      end
   end

   // ****************************************
   // Mode selection
   // ****************************************
   // Config strap caught after release, never under async reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_loaded          <= 1'b0;
         double_speed_select <= 1'b0;
      end else if (!cfg_loaded) begin
         cfg_loaded          <= 1'b1;
         double_speed_select <= hardware_config_byte_dbl_i;
      end else if (wr_mode) begin
         double_speed_select <= wdata_i[`OCP_MODE_DBL_BIT];
      end
   end

   // Oscillator divided by two reference
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div2 <= 1'b0;
      end else begin
         div2 <= ~div2;
      end
   end

   // Sampled only as div2 rises, so no runt phase at a switch
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dbl_active <= 1'b0;
      end else if (!div2) begin
         dbl_active <= double_speed_select;
      end
   end

   // ****************************************
   // Divider
   // ****************************************
   wire ocp_cnt_t span     = `OCP_RELOAD_SPAN - {2'b00, clock_divider_reload};
   wire           fastest  = (clock_divider_reload == `OCP_FASTEST);
   wire ocp_cnt_t per_dbl  = fastest ? `OCP_PER_DBL_FAST
                                     : {span[8:0], 1'b0};
   wire ocp_cnt_t per_std  = fastest ? `OCP_PER_STD_FAST
                                     : {span[7:0], 2'b00};
   wire ocp_cnt_t next_per = dbl_active ? per_dbl : per_std;
   wire           tick     = (cnt == 10'h001);
   wire ocp_cnt_t next_cnt = tick ? next_per : cnt - 10'h001;

   // Reload taken only at terminal count; phases never cut short
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= `OCP_PER_STD_FAST;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Both enables from one tick keep CPU and peripherals equal
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_clk_en_o    <= 1'b0;
         periph_clk_en_o <= 1'b0;
      end else begin
         cpu_clk_en_o    <= tick;
         periph_clk_en_o <= tick;
      end
   end

   // Single oscillator, always selected and passed undivided
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_clk_en_o               <= 1'b1;
         oscillator_source_select_o <= 1'b1;
      end else begin
         osc_clk_en_o               <= 1'b1;
         oscillator_source_select_o <= 1'b1;
      end
   end

   // Machine cycle length follows active mode
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         double_speed_o          <= 1'b0;
         osc_per_machine_cycle_o <= `OCP_OSC_STD_MC;
      end else begin
         double_speed_o          <= dbl_active;
         osc_per_machine_cycle_o <= dbl_active ? `OCP_OSC_DBL_MC : `OCP_OSC_STD_MC;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   ocp_cnt_t gap;
   ocp_cnt_t per_q;
   logic     armed;
   // Helper: spacing between ticks versus period loaded
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gap   <= 10'h001;
         per_q <= `OCP_PER_STD_FAST;
         armed <= 1'b0;
      end else if (tick) begin
         gap   <= 10'h001;
         per_q <= next_per;
         armed <= 1'b1;
      end else begin
         gap   <= gap + 10'h001;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // Properties see registered state; reset masks every one
   a_tick_spacing:   assert property (tick && armed |-> gap == per_q)
      else $error("divider tick spacing wrong");
   a_clocks_equal:   assert property (cpu_clk_en_o == periph_clk_en_o)
      else $error("cpu and peripheral enables differ");
   a_reload_write:   assert property (
      wr_reload |=> clock_divider_reload == $past(wdata_i))
      else $error("reload write lost");
   a_slowest_std:    assert property (
      clock_divider_reload == 8'h00 && !dbl_active |-> next_per == 10'd1020)
      else $error("slowest standard period wrong");
   a_slowest_dbl:    assert property (
      clock_divider_reload == 8'h00 && dbl_active |-> next_per == 10'd510)
      else $error("slowest double speed period wrong");
   a_fastest_rate:   assert property (
      fastest |-> next_per == (dbl_active ? 10'd1 : 10'd2))
      else $error("fastest period wrong");
   a_dbl_formula:    assert property (
      !fastest && dbl_active |-> next_per == 10'd2 * (10'd255 - clock_divider_reload))
      else $error("double speed formula wrong");
   a_std_formula:    assert property (
      !fastest && !dbl_active |-> next_per == 10'd4 * (10'd255 - clock_divider_reload))
      else $error("standard formula wrong");
   a_mode_on_div2:   assert property ($changed(dbl_active) |-> div2 && !$past(div2))
      else $error("mode changed off div2 rising edge");
   a_mode_steady:    assert property (div2 |=> $stable(dbl_active))
      else $error("mode changed while div2 high");
   a_mode_follow:    assert property (
      double_speed_select != dbl_active |-> ##[1:2] dbl_active == $past(double_speed_select))
      else $error("mode not applied within two cycles");
   a_mc_periods:     assert property (
      osc_per_machine_cycle_o == (double_speed_o ? 4'd6 : 4'd12))
      else $error("machine cycle length wrong");
   a_osc_selected:   assert property (oscillator_source_select_o && osc_clk_en_o)
      else $error("oscillator not selected");

   // Main scenarios: slowest, mode switch, reload change, fastest
   c_slow_tick:      cover property (tick && clock_divider_reload == 8'h00 && !dbl_active);
   c_mode_switch:    cover property ($rose(dbl_active));
   c_reload_change:  cover property (wr_reload ##1 tick);
   c_fast_dbl:       cover property (tick && fastest && dbl_active ##1 tick);
endmodule
`default_nettype wire

// *** bench/ocp_clock_sink.sv ***
`timescale 1ns/10ps
`default_nettype none
// Clock consumer: measures the divided period and watches CPU/peripheral agreement
module ocp_clock_sink (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        cpu_clk_en_i,
   input  wire logic        periph_clk_en_i,
   output logic [11:0]      per_o,
   output logic             same_o
);
   logic [11:0] cnt;
   // Cycles between pulses; a stuck enable leaves per_o stale, so bench waits bounded
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt    <= 12'h000;
         per_o  <= 12'h000;
         same_o <= 1'b1;
      end else begin
         cnt <= (cpu_clk_en_i === 1'b1) ? 12'h001 : cnt + 12'h001;
         if (cpu_clk_en_i === 1'b1) per_o <= cnt;
         if (cpu_clk_en_i !== periph_clk_en_i) same_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** bench/oscillator_clock_prescaler_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module oscillator_clock_prescaler_tb;
   import ocp_pkg::*;
   logic clk_i, arst_n_i, strap, we_i, re_i;
   ocp_byte_t addr_i, wdata_i, rdata_o, d, r;
   logic cpu_en, per_en, osc_en, sel, ds;
   logic [3:0] mc;
   logic [11:0] per;
   logic same, dbl;
   int n_fail, n_compared, i, seed;
   ocp_prescaler ocp_prescaler_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .hardware_config_byte_dbl_i(strap), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .cpu_clk_en_o(cpu_en),
      .periph_clk_en_o(per_en), .osc_clk_en_o(osc_en),
      .oscillator_source_select_o(sel), .double_speed_o(ds),
      .osc_per_machine_cycle_o(mc));
   ocp_clock_sink ocp_clock_sink_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .cpu_clk_en_i(cpu_en), .periph_clk_en_i(per_en), .per_o(per), .same_o(same));
   // ****************************************
   // Helpers
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      $display("counts: compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycles: one strobe cycle, read data taken in the following cycle
   task automatic wr(input ocp_byte_t a, input ocp_byte_t v);
      @(posedge clk_i) begin we_i <= 1'b1; addr_i <= a; wdata_i <= v; end
      @(posedge clk_i) we_i <= 1'b0;
   endtask
   task automatic rd(input ocp_byte_t a, output ocp_byte_t v);
      @(posedge clk_i) begin re_i <= 1'b1; addr_i <= a; end
      @(posedge clk_i) re_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk_i) begin arst_n_i <= 1'b0; strap <= s; end
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   // Bounded wait; a missing pulse ends the run
   task automatic wait_pulse;
      int k;
      for (k = 0; k < 2100; k++) begin
         @(posedge clk_i);
         #1;
         if (cpu_en === 1'b1) break;
      end
      if (k == 2100) begin
         n_fail++;
         $display("timeout waiting for divided clock");
         give_verdict();
      end
   endtask
   // Expected period: FFh is the special fastest case
   function automatic logic [11:0] exp_per(input ocp_byte_t v, input logic m);
      if (v === 8'hFF) return m ? 12'h001 : 12'h002;
      return (12'h0FF - {4'h0, v}) << (m ? 1 : 2);
   endfunction
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {arst_n_i, strap, we_i, re_i, addr_i, wdata_i} = '0;
      n_fail = 0;
      n_compared = 0;
      seed = 32'h9529F9B1;
      do_reset(1'b0);
      rd(8'h97, d);
      chk({4'h0, d}, 12'h0FF);
      chk({10'h000, osc_en, sel}, 12'h003);
      rd(8'h90, d);
      chk({4'h0, d}, 12'h000);
      wr(8'h90, 8'h5A);
      rd(8'h97, d);
      chk({4'h0, d}, 12'h0FF);
      @(posedge clk_i);
      #1 chk({4'h0, rdata_o}, 12'h000);
      $display("test reset done");
      for (i = 0; i < 10; i++) begin
         dbl = i[0];
         r = (i < 2) ? 8'hFF : (i < 4) ? 8'h00 : (i < 6) ? 8'hFE : 8'($random(seed));
         wr(8'h8F, {7'h00, dbl});
         wr(8'h97, r);
         repeat (3) wait_pulse();
         @(posedge clk_i);
         #1 chk(per, exp_per(r, dbl));
         chk({11'h000, ds}, {11'h000, dbl});
         chk({8'h00, mc}, dbl ? 12'h006 : 12'h00C);
         rd(8'h97, d);
         chk({4'h0, d}, {4'h0, r});
      end
      chk({11'h000, same}, 12'h001);
      $display("test division done");
      do_reset(1'b1);
      rd(8'h8F, d);
      chk({4'h0, d}, 12'h003);
      rd(8'h97, d);
      chk({4'h0, d}, 12'h0FF);
      $display("test strap done");
      give_verdict();
   end
endmodule
`default_nettype wire
